/* core/oabs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module oabs_top
	import oabs_pkg::*;
#(
	parameter logic [20:0] P_CNT1 = OABS_CNT1,
	parameter logic [20:0] P_CNT2 = OABS_CNT2,
	parameter logic [20:0] P_CNT3 = OABS_CNT3,
	parameter logic [20:0] P_CNT4 = OABS_CNT4
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// Register port from the serial bus engine
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_oem_pw_ok,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic [3:0] o_serial_addr_upper,
	// Non-volatile image loaded after reset
	input wire logic i_nv_load,
	input wire logic [7:0] i_nv_cfg2,
	input wire logic [7:0] i_nv_set0,
	input wire logic [7:0] i_nv_set1,
	input wire logic [7:0] i_nv_set2,
	output logic o_nv_wr,
	output logic [7:0] o_nv_addr,
	output logic [7:0] o_nv_data,
	// Reset output control
	input wire logic i_reset_mode,
	input wire logic i_general_purpose_output,
	input wire logic [2:0] i_reset_out_flags_set,
	output logic [2:0] o_reset_out_flags,
	// Bias path
	input wire logic i_power_control_loop,
	input wire logic i_dac_cal_mode,
	input wire logic [1:0] i_bias_sel,
	input wire logic [7:0] i_bias_comp_table,
	output logic [7:0] o_bias_dac
);
	// ********************
	// Storage
	// ********************
	logic [7:0] oem_config_two;
	logic [7:0] bias_setpoint [3];
	logic gpo_s1, gpo_s2, gpo_s3;
	logic clear;
	logic wr_ok;
	logic [9:0] sum;
	logic [7:0] sel_sp;
	logic [7:0] next_dac;
	default clocking cb_ref @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);
	// Password gates every access to this bank.
	assign wr_ok = i_wr && i_oem_pw_ok;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			oem_config_two <= OABS_CFG2_RST;
		end else if (i_nv_load) begin
			oem_config_two <= i_nv_cfg2;
		end else if (wr_ok && i_addr == OABS_ADDR_CFG2) begin
			oem_config_two <= i_wdata;
		end
	end
	// The engine compares against this from the next access on.
	assign o_serial_addr_upper =
		oem_config_two[OABS_SADR_MSB:OABS_SADR_LSB];
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sp
			always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					bias_setpoint[g] <= OABS_SET_RST;
				end else if (i_nv_load) begin
					bias_setpoint[g] <= (g == 0) ? i_nv_set0 :
						(g == 1) ? i_nv_set1 : i_nv_set2;
				end else if (wr_ok && i_addr == OABS_ADDR_SET0 + 8'(g)) begin
					bias_setpoint[g] <= i_wdata;
				end
			end
		end
	endgenerate
	// Writes are mirrored to the non-volatile store so they survive resets.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_nv_wr <= 1'b0;
			o_nv_addr <= 8'h00;
			o_nv_data <= 8'h00;
		end else begin
			o_nv_wr <= wr_ok && i_addr >= OABS_ADDR_CFG2 &&
				i_addr <= OABS_ADDR_SET2;
			o_nv_addr <= i_addr;
			o_nv_data <= i_wdata;
		end
	end
	// ********************
	// Read port
	// ********************
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			o_rdata <= 8'h00;
			if (i_rd && i_addr == OABS_ADDR_DACRB) begin
				o_rdata <= o_bias_dac;
			end else if (i_rd && i_oem_pw_ok) begin
				unique case (i_addr)
					OABS_ADDR_CFG2: o_rdata <= {oem_config_two[7:4], 1'b0,
						oem_config_two[2:0]};
					OABS_ADDR_SET0: o_rdata <= bias_setpoint[0];
					OABS_ADDR_SET1: o_rdata <= bias_setpoint[1];
					OABS_ADDR_SET2: o_rdata <= bias_setpoint[2];
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end
	// ********************
	// Bias DAC
	// ********************
	// Code 3 of the selector is unused and falls back to setpoint 0.
	assign sel_sp = (i_bias_sel == 2'h1) ? bias_setpoint[1] :
		(i_bias_sel == 2'h2) ? bias_setpoint[2] : bias_setpoint[0];
	always_comb begin
		if (i_dac_cal_mode) begin
			sum = {2'b00, sel_sp};
		end else begin
			sum = {2'b00, sel_sp} + {{2{i_bias_comp_table[7]}},
				i_bias_comp_table};
		end
		if (sum[9]) begin
			next_dac = 8'h00;
		end else if (sum[8]) begin
			next_dac = 8'hff;
		end else begin
			next_dac = sum[7:0];
		end
	end
	// Setpoint registers change by a write or an NV load; in cal or loop mode the DAC follows next edge.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_bias_dac <= 8'h00;
		end else if (i_dac_cal_mode || i_power_control_loop) begin
			o_bias_dac <= next_dac;
		end
	end
	// ********************
	// Reset output flags
	// ********************
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gpo_s1 <= 1'b0;
			gpo_s2 <= 1'b0;
			gpo_s3 <= 1'b0;
		end else begin
			gpo_s1 <= i_general_purpose_output;
			gpo_s2 <= gpo_s1;
			gpo_s3 <= gpo_s2;
		end
	end
	oabs_rst_delay #(
		.P_CNT1(P_CNT1),
		.P_CNT2(P_CNT2),
		.P_CNT3(P_CNT3),
		.P_CNT4(P_CNT4)
	) u_dly (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_reset_mode(i_reset_mode),
		.i_gpo_fall(gpo_s3 && !gpo_s2),
		.i_reset_clear_delay(oem_config_two[OABS_DLY_MSB:0]),
		.o_clear(clear)
	);
	// A new set wins over the delayed clear.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reset_out_flags <= 3'h0;
		end else begin
			o_reset_out_flags <= (clear ? 3'h0 : o_reset_out_flags) |
				i_reset_out_flags_set;
		end
	end
	// ********************
	// Checks
	// ********************
	a_pw_block: assert property (
		i_wr && !i_oem_pw_ok && !i_nv_load |=>
		$stable(oem_config_two) && $stable(bias_setpoint[0]))
		else $error("write without password changed a register");
	a_addr_now: assert property (
		wr_ok && !i_nv_load && i_addr == OABS_ADDR_CFG2 |=>
		o_serial_addr_upper == $past(i_wdata[7:4]))
		else $error("address field not applied at once");
	a_cal_raw: assert property (
		i_dac_cal_mode |=> o_bias_dac == $past(sel_sp))
		else $error("calibration mode did not pass raw setpoint");
	a_clamp_hi: assert property (
		i_power_control_loop && !i_dac_cal_mode && !i_bias_comp_table[7] &&
		({1'b0, sel_sp} + {1'b0, i_bias_comp_table}) > 9'h0ff |=>
		o_bias_dac == 8'hff)
		else $error("sum not clamped high");
	a_readback: assert property (
		i_rd && i_addr == OABS_ADDR_DACRB && !i_dac_cal_mode &&
		!i_power_control_loop |=> o_rdata == o_bias_dac)
		else $error("readback differs from dac code");
	a_no_mode: assert property (
		!i_reset_mode |=> !clear)
		else $error("clear outside reset mode");
	a_zero_dly: assert property (
		i_reset_mode && gpo_s3 && !gpo_s2 && oem_config_two[2:0] == 3'h0
		|=> clear)
		else $error("zero delay code did not clear at once");
	a_flags_clr: assert property (
		clear && i_reset_out_flags_set == 3'h0 |=> o_reset_out_flags == 3'h0)
		else $error("flags not cleared");
	a_sel_one: assert property (
		i_dac_cal_mode && i_bias_sel == 2'h1 |=>
		o_bias_dac == $past(bias_setpoint[1]))
		else $error("selector ignored");
	c_clear: cover property (clear);
	c_cfg_wr: cover property (wr_ok && i_addr == OABS_ADDR_CFG2);
	c_clamp0: cover property (sum[9] && i_power_control_loop);
endmodule
`default_nettype wire

/* core/oabs_pkg.sv */
// Function
// - Bits 7 to 4 of the second OEM configuration register form the top four bits of the device serial address.
// - A new serial address upper field takes effect from the very next bus access.
// - The second OEM configuration register and the three bias setpoints are reachable only with a valid OEM password.
// - The second OEM configuration register and the bias setpoints are non-volatile across power cycles and resets.
// - In reset mode all three reset-output flags clear a programmed delay after the general output de-asserts.
// - Delay code 000 is zero, 001 is 17.5 ms, 010 is 22.5 ms, 011 is 27.0 ms and 100 is 45 ms.
// - The reset clear delay field defaults to the 22.5 ms code.
// - Every produced delay lies within ten percent of its nominal value.
// - Outside reset mode the reset clear delay field has no effect.
// - With the power control loop on, the signed table offset is added to the selected setpoint and loaded into the bias DAC.
// - In DAC calibration mode a write to the selected bias setpoint updates the bias DAC at once.
// - In DAC calibration mode the table offset is forced to zero.
// - The code driving the bias DAC can always be read back.
`default_nettype none
package oabs_pkg;
	// ********************
	// Register map
	// ********************
	localparam logic [7:0] OABS_ADDR_CFG2 = 8'h02;
	localparam logic [7:0] OABS_ADDR_SET0 = 8'h03;
	localparam logic [7:0] OABS_ADDR_SET1 = 8'h04;
	localparam logic [7:0] OABS_ADDR_SET2 = 8'h05;
	localparam logic [7:0] OABS_ADDR_DACRB = 8'h10;
	localparam int OABS_SADR_MSB = 7;
	localparam int OABS_SADR_LSB = 4;
	localparam int OABS_DLY_MSB = 2;
	localparam logic [7:0] OABS_CFG2_RST = 8'h02;
	localparam logic [7:0] OABS_SET_RST = 8'h00;
	// ********************
	// Timing
	// ********************
	localparam longint OABS_CLK_HZ = 20000000;
	localparam int OABS_DLY1_US = 17500;
	localparam int OABS_DLY2_US = 22500;
	localparam int OABS_DLY3_US = 27000;
	localparam int OABS_DLY4_US = 45000;
	localparam logic [20:0] OABS_CNT1 = 21'(OABS_DLY1_US * OABS_CLK_HZ / 1000000);
	localparam logic [20:0] OABS_CNT2 = 21'(OABS_DLY2_US * OABS_CLK_HZ / 1000000);
	localparam logic [20:0] OABS_CNT3 = 21'(OABS_DLY3_US * OABS_CLK_HZ / 1000000);
	localparam logic [20:0] OABS_CNT4 = 21'(OABS_DLY4_US * OABS_CLK_HZ / 1000000);
endpackage
`default_nettype wire

/* core/oabs_rst_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module oabs_rst_delay
	import oabs_pkg::*;
#(
	parameter logic [20:0] P_CNT1 = OABS_CNT1,
	parameter logic [20:0] P_CNT2 = OABS_CNT2,
	parameter logic [20:0] P_CNT3 = OABS_CNT3,
	parameter logic [20:0] P_CNT4 = OABS_CNT4
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// Control
	input wire logic i_reset_mode,
	input wire logic i_gpo_fall,
	input wire logic [2:0] i_reset_clear_delay,
	// Result
	output logic o_clear
);
	logic [20:0] cnt;
	logic busy;
	logic [20:0] load;
	// Codes above 100 are undefined; they clear at once like 000.
	always_comb begin
		unique case (i_reset_clear_delay)
			3'h1: load = P_CNT1;
			3'h2: load = P_CNT2;
			3'h3: load = P_CNT3;
			3'h4: load = P_CNT4;
			default: load = 21'h0;
		endcase
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= 21'h0;
			busy <= 1'b0;
			o_clear <= 1'b0;
		end else begin
			o_clear <= 1'b0;
			if (!i_reset_mode) begin
				busy <= 1'b0;
			end else if (i_gpo_fall) begin
				if (load == 21'h0) begin
					o_clear <= 1'b1;
					busy <= 1'b0;
				end else begin
					cnt <= load - 21'h1;
					busy <= 1'b1;
				end
			end else if (busy) begin
				if (cnt == 21'h0) begin
					o_clear <= 1'b1;
					busy <= 1'b0;
				end else begin
					cnt <= cnt - 21'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verification/oabs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module oabs_host_model (
	// Clock
	input wire logic i_ref_clk,
	// Answers
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	// Requests
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	logic [3:0] target_upper;
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		target_upper = 4'h0;
	end
	// Released request lines show the inverse of the last value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_ref_clk);
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		if (a == 8'h02) begin
			target_upper = d[7:4];
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		int i;
		@(negedge i_ref_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_ref_clk);
		o_rd = 1'b0;
		o_addr = ~a;
		ok = 1'b0;
		d = 8'hxx;
		for (i = 0; i < 3 && !ok; i++) begin
			if (i_rvalid === 1'b1) begin
				d = i_rdata;
				ok = 1'b1;
			end else begin
				@(negedge i_ref_clk);
			end
		end
	endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import oabs_pkg::*;
	logic clk, arst_n, wr, rd, pw_ok, rvalid, nv_load, nv_wr;
	logic rst_mode, gpo, pcl, cal;
	logic [7:0] addr, wdata, rdata, nv_cfg2, nv_set0, nv_set1, nv_set2;
	logic [7:0] nv_addr, nv_data, table_off, dac;
	logic [3:0] sa_upper;
	logic [2:0] flags_set, flags;
	logic [1:0] sel;
	int mismatches, check_count;
	int cnt[5] = '{0, 10, 20, 30, 40};
	oabs_top #(.P_CNT1(21'd10), .P_CNT2(21'd20), .P_CNT3(21'd30),
		.P_CNT4(21'd40)) dut (.i_ref_clk(clk), .i_arst_n(arst_n),
		.i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
		.i_oem_pw_ok(pw_ok), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_serial_addr_upper(sa_upper), .i_nv_load(nv_load),
		.i_nv_cfg2(nv_cfg2), .i_nv_set0(nv_set0), .i_nv_set1(nv_set1),
		.i_nv_set2(nv_set2), .o_nv_wr(nv_wr), .o_nv_addr(nv_addr),
		.o_nv_data(nv_data), .i_reset_mode(rst_mode),
		.i_general_purpose_output(gpo), .i_reset_out_flags_set(flags_set),
		.o_reset_out_flags(flags), .i_power_control_loop(pcl),
		.i_dac_cal_mode(cal), .i_bias_sel(sel),
		.i_bias_comp_table(table_off), .o_bias_dac(dac));
	oabs_host_model host (.i_ref_clk(clk), .i_rdata(rdata),
		.i_rvalid(rvalid), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata));
	// ********************
	// Checking helpers
	// ********************
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int n, input int lo, input int hi);
		check_count++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, n, lo);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd(a, d, ok);
		if (!ok) begin
			mismatches++;
			end_of_test();
		end
		chk8(d, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic sc_defaults();
		rd_chk(OABS_ADDR_CFG2, OABS_CFG2_RST);
		rd_chk(OABS_ADDR_SET2, OABS_SET_RST);
		chk8({4'h0, sa_upper}, 8'h00);
	endtask
	task automatic sc_password();
		host.wr(OABS_ADDR_SET0, 8'h3c);
		pw_ok = 1'b0;
		host.wr(OABS_ADDR_SET0, 8'h5a);
		chk8({7'h0, nv_wr}, 8'h00);
		host.wr(OABS_ADDR_CFG2, 8'hf7);
		chk8({4'h0, sa_upper}, 8'h00);
		rd_chk(OABS_ADDR_SET0, 8'h00);
		pw_ok = 1'b1;
		rd_chk(OABS_ADDR_SET0, 8'h3c);
		rd_chk(OABS_ADDR_CFG2, OABS_CFG2_RST);
	endtask
	task automatic sc_serial_addr();
		host.wr(OABS_ADDR_CFG2, 8'hab);
		chk8({7'h0, nv_wr}, 8'h01);
		chk8(nv_addr, OABS_ADDR_CFG2);
		chk8(nv_data, 8'hab);
		chk8({4'h0, sa_upper}, {4'h0, host.target_upper});
		rd_chk(OABS_ADDR_CFG2, 8'ha3);
		host.wr(OABS_ADDR_CFG2, 8'h52);
		chk8({4'h0, sa_upper}, 8'h05);
		nv_cfg2 = 8'h34;
		nv_set0 = 8'h11;
		nv_set1 = 8'h22;
		nv_set2 = 8'h33;
		nv_load = 1'b1;
		cyc(1);
		nv_load = 1'b0;
		rd_chk(OABS_ADDR_CFG2, 8'h34);
		rd_chk(OABS_ADDR_SET1, 8'h22);
		chk8({4'h0, sa_upper}, 8'h03);
	endtask
	task automatic sc_cal();
		int k;
		cal = 1'b1;
		table_off = 8'h80;
		for (k = 0; k < 4; k++) begin
			sel = 2'(k);
			host.wr(OABS_ADDR_SET0 + 8'(k % 3), 8'h90 + 8'(k));
			cyc(3);
			chk8(dac, 8'h90 + 8'(k));
			rd_chk(OABS_ADDR_DACRB, 8'h90 + 8'(k));
		end
		cal = 1'b0;
		rd_chk(OABS_ADDR_DACRB, 8'h93);
	endtask
	task automatic sc_loop();
		logic [7:0] sp[4] = '{8'h10, 8'hf0, 8'h05, 8'h40};
		logic [7:0] tv[4] = '{8'hf0, 8'h20, 8'hf0, 8'h05};
		logic [7:0] ex[4] = '{8'h00, 8'hff, 8'h00, 8'h45};
		int k;
		pcl = 1'b1;
		sel = 2'd2;
		for (k = 0; k < 4; k++) begin
			table_off = tv[k];
			host.wr(OABS_ADDR_SET2, sp[k]);
			cyc(3);
			chk8(dac, ex[k]);
		end
		pcl = 1'b0;
	endtask
	task automatic flag_cycle(input logic [2:0] code, input logic live,
		output int n);
		host.wr(OABS_ADDR_CFG2, {5'h0a, code});
		flags_set = 3'h7;
		gpo = 1'b1;
		cyc(1);
		flags_set = 3'h0;
		cyc(4);
		gpo = 1'b0;
		n = 0;
		while (flags !== 3'h0 && n < 100) begin
			cyc(1);
			n++;
		end
		if (live && n >= 100) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic sc_delay();
		int k, n;
		rst_mode = 1'b1;
		for (k = 0; k < 5; k++) begin
			flag_cycle(3'(k), 1'b1, n);
			chk_rng(n, cnt[k], cnt[k] + 8);
		end
		rst_mode = 1'b0;
		flag_cycle(3'h1, 1'b0, n);
		chk8({5'h0, flags}, 8'h07);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{arst_n, pw_ok, nv_load, rst_mode, gpo, pcl, cal} = 7'h00;
		{nv_cfg2, nv_set0, nv_set1, nv_set2, table_off} = 40'h0;
		flags_set = 3'h0;
		sel = 2'd0;
		mismatches = 0;
		check_count = 0;
		cyc(8);
		arst_n = 1'b1;
		pw_ok = 1'b1;
		sc_defaults();
		sc_password();
		sc_serial_addr();
		sc_cal();
		sc_loop();
		sc_delay();
		end_of_test();
	end
endmodule
`default_nettype wire
